// [common/latch_cfg.svh]
// constants for the set-reset latch block: offsets, field positions, reset values
// assumes a byte-wide register port and one 100 MHz clock
`ifndef LATCH_CFG_SVH
`define LATCH_CFG_SVH

// register port
`define LATCH_ADDR_W        2
`define LATCH_DATA_W        8
`define LATCH_OFS_MAIN      2'h0
`define LATCH_OFS_SRC       2'h1

// latch_control_main fields
`define LATCH_BIT_ENABLE    7
`define LATCH_DIV_HI        6
`define LATCH_DIV_LO        4
`define LATCH_BIT_QEN       3
`define LATCH_BIT_NQEN      2
`define LATCH_BIT_FW_SET    1
`define LATCH_BIT_FW_RST    0

// latch_source_select fields
`define LATCH_BIT_PIN_SET   7
`define LATCH_BIT_CLK_SET   6
`define LATCH_BIT_C2_SET    5
`define LATCH_BIT_C1_SET    4
`define LATCH_BIT_PIN_RST   3
`define LATCH_BIT_CLK_RST   2
`define LATCH_BIT_C2_RST    1
`define LATCH_BIT_C1_RST    0

// reset values and read masks
`define LATCH_MAIN_RESET    8'h00
`define LATCH_SRC_RESET     8'h00
`define LATCH_MAIN_RD_MASK  8'hFC
`define LATCH_RD_ZERO       8'h00

// firmware pulse width in clock cycles
`define LATCH_FW_PULSE      2'h2
`define LATCH_CNT_ZERO      2'h0
`define LATCH_CNT_ONE       2'h1

// pulse divider: smallest ratio is 4, counter covers the 512 ratio
`define LATCH_DIV_CNT_W     9
`define LATCH_DIV_BASE      9'h004
`define LATCH_DIV_ONE       9'h001
`define LATCH_DIV_ZERO      9'h000
`define LATCH_DIV_SEL_W     3

`endif

// [common/latch_pkg.sv]
// types of the set-reset latch block
// assumes latch_cfg.svh gives the widths
`include "latch_cfg.svh"

package latch_pkg;

    // register state of the latch top
    typedef struct packed {
        logic [`LATCH_DATA_W-1:0] ctl;
        logic [`LATCH_DATA_W-1:0] src;
        logic [1:0]               set_cnt;
        logic [1:0]               rst_cnt;
        logic [1:0]               c1_sy;
        logic [1:0]               c2_sy;
        logic [1:0]               int_sy;
        logic                     state;
        logic                     known;
        logic [`LATCH_DATA_W-1:0] rdata;
        logic                     pin_out;
        logic                     pin_oe;
        logic                     q;
        logic                     qn;
    } latch_state_s;

    // register state of the pulse divider
    typedef struct packed {
        logic [`LATCH_DIV_CNT_W-1:0] cnt;
        logic [`LATCH_DIV_SEL_W-1:0] sel_d;
        logic                        tick;
    } div_state_s;

endpackage

// [common/pulse_div_if.sv]
// link between the latch top and its pulse divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "latch_cfg.svh"

interface pulse_div_if;
    logic                        en;
    logic [`LATCH_DIV_SEL_W-1:0] sel;
    logic                        tick;

    modport divider (input en, input sel, output tick);
    modport user    (output en, output sel, input tick);
endinterface

// [hdl/pulse_divider.sv]
// divided pulse clock for the latch: one-cycle tick every 4..512 cycles
// assumes clk is the peripheral cycle clock and rst is synchronous
`timescale 1ns/1ps
`include "latch_cfg.svh"

module pulse_divider (
    input  wire logic   clk,
    input  wire logic   rst,
    pulse_div_if.divider dv
);

    latch_pkg::div_state_s st_ff;
    latch_pkg::div_state_s nxt_st;

    // ratio 4 << sel, minus one, as the compare mask
    function automatic logic [`LATCH_DIV_CNT_W-1:0] div_mask(
        input logic [`LATCH_DIV_SEL_W-1:0] sel);
        div_mask = (`LATCH_DIV_BASE << sel) - `LATCH_DIV_ONE;
    endfunction

    // count while enabled; restart when the ratio changes to limit stray ticks
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sel_d = dv.sel;
        if (!dv.en || dv.sel != st_ff.sel_d) begin
            nxt_st.cnt = `LATCH_DIV_ZERO;
        end else begin
            nxt_st.cnt = st_ff.cnt + `LATCH_DIV_ONE;
        end
        nxt_st.tick = dv.en && (dv.sel == st_ff.sel_d)
                      && ((st_ff.cnt & div_mask(dv.sel)) == div_mask(dv.sel)); // R2
        if (rst) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign dv.tick = st_ff.tick;

    // ticks are never closer than the smallest ratio
    chk_div_min_gap: assert property (@(posedge clk) disable iff (rst) // R2
        st_ff.tick |=> !st_ff.tick [*3])
        else $error("divider ticks closer than four cycles");

endmodule

// [hdl/sr_latch_control.sv]
// set-reset latch with selectable sources, divided pulse clock and pin steering
// assumes a byte register port, async comparator and pin inputs, one clock
//
// How it works
// [R1] top control bit enables latch operation
// [R2] divider select gives ratios four through 512
// [R3] software keeps divider fixed while latch enabled
// [R4] true output drives pin when inverted off
// [R5] inverted output enable wins, drives pin
// [R6] firmware set bit pulses set, reads zero
// [R7] firmware reset bit pulses reset, reads zero
// [R8] four enables let sources set latch
// [R9] four enables let sources reset latch
// [R10] clock set enable pulses set input periodically
// [R11] clock reset enable pulses reset input periodically
// [R12] both control registers reset to zero, read/write
// [R13] active high inputs, reset dominates set
// [R14] device reset leaves latch state untouched; code keeps the state bit but holds latch_q, latch_qn low until set or reset
// [R15] disabled or no enable: pin is port
// [R16] firmware pulse lasts two clock cycles
// [R17] set and reset inputs OR their sources
// [R18] firmware pulse bits clear themselves
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "latch_cfg.svh"

module sr_latch_control (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [`LATCH_ADDR_W-1:0] reg_addr,
    input  wire logic [`LATCH_DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_we,
    input  wire logic                     reg_re,
    output logic      [`LATCH_DATA_W-1:0] reg_rdata,
    input  wire logic                     comparator_one_output,
    input  wire logic                     comparator_two_output,
    input  wire logic                     external_interrupt_pin_one,
    input  wire logic                     port_data_out,
    input  wire logic                     port_drive_en,
    output logic                          latch_output_port_pin_out,
    output logic                          latch_output_port_pin_oe,
    output logic                          latch_q,
    output logic                          latch_qn
);

    latch_pkg::latch_state_s st_ff;
    latch_pkg::latch_state_s nxt_st;

    pulse_div_if div_if ();

    logic                     latch_on;
    logic [`LATCH_DIV_SEL_W-1:0] div_sel;
    logic                     qen;
    logic                     nqen;
    logic                     c1_s;
    logic                     c2_s;
    logic                     int_s;
    logic                     fw_set_act;
    logic                     fw_rst_act;
    logic                     set_req;
    logic                     rst_req;
    logic                     wr_main;
    logic                     wr_src;
    logic                     wr_fw_set;
    logic                     wr_fw_rst;
    logic                     drive_latch;
    logic                     pin_level;

    // divided pulse clock for the clock-driven sources
    pulse_divider u_div (
        .clk (clk),
        .rst (rst),
        .dv  (div_if.divider)
    );

    // control fields as seen by the logic
    assign latch_on = st_ff.ctl[`LATCH_BIT_ENABLE];                   // R1
    assign div_sel  = st_ff.ctl[`LATCH_DIV_HI:`LATCH_DIV_LO];
    assign qen      = st_ff.ctl[`LATCH_BIT_QEN];
    assign nqen     = st_ff.ctl[`LATCH_BIT_NQEN];

    // divider runs only while the latch is enabled; ratio changes then are
    // the software's hazard and the divider restarts its count
    assign div_if.en  = latch_on;
    assign div_if.sel = div_sel;                                      // R2 R3

    // second synchroniser stage is the only one the logic reads
    assign c1_s  = st_ff.c1_sy[1];
    assign c2_s  = st_ff.c2_sy[1];
    assign int_s = st_ff.int_sy[1];

    // firmware pulses are active while their counter runs
    assign fw_set_act = (st_ff.set_cnt != `LATCH_CNT_ZERO);
    assign fw_rst_act = (st_ff.rst_cnt != `LATCH_CNT_ZERO);

    // set input: OR of every enabled source and the firmware pulse
    assign set_req = latch_on && (                                    // R1 R17
        (st_ff.src[`LATCH_BIT_PIN_SET] && int_s)                      // R8
        || (st_ff.src[`LATCH_BIT_CLK_SET] && div_if.tick)             // R10
        || (st_ff.src[`LATCH_BIT_C2_SET] && c2_s)                     // R8
        || (st_ff.src[`LATCH_BIT_C1_SET] && c1_s)                     // R8
        || fw_set_act);                                               // R6

    // reset input: same structure on the reset enables
    assign rst_req = latch_on && (                                    // R1 R17
        (st_ff.src[`LATCH_BIT_PIN_RST] && int_s)                      // R9
        || (st_ff.src[`LATCH_BIT_CLK_RST] && div_if.tick)             // R11
        || (st_ff.src[`LATCH_BIT_C2_RST] && c2_s)                     // R9
        || (st_ff.src[`LATCH_BIT_C1_RST] && c1_s)                     // R9
        || fw_rst_act);                                               // R7

    // register port decode
    assign wr_main   = reg_we && (reg_addr == `LATCH_OFS_MAIN);
    assign wr_src    = reg_we && (reg_addr == `LATCH_OFS_SRC);
    assign wr_fw_set = wr_main && reg_wdata[`LATCH_BIT_FW_SET];
    assign wr_fw_rst = wr_main && reg_wdata[`LATCH_BIT_FW_RST];

    // pin steering: inverted output has priority over the true output
    assign drive_latch = latch_on && (qen || nqen);                   // R15
    assign pin_level   = nqen ? !st_ff.state : st_ff.state;           // R4 R5

    // next state of the whole block
    always_comb begin
        nxt_st = st_ff;

        // two-stage synchronisers for the asynchronous inputs
        nxt_st.c1_sy  = {st_ff.c1_sy[0], comparator_one_output};
        nxt_st.c2_sy  = {st_ff.c2_sy[0], comparator_two_output};
        nxt_st.int_sy = {st_ff.int_sy[0], external_interrupt_pin_one};

        // register writes; pulse bits are never stored
        if (wr_main) begin
            nxt_st.ctl = reg_wdata & `LATCH_MAIN_RD_MASK;             // R6 R7 R12
        end
        if (wr_src) begin
            nxt_st.src = reg_wdata;                                   // R12
        end

        // firmware pulse counters load on the write and run down alone
        if (wr_fw_set) begin
            nxt_st.set_cnt = `LATCH_FW_PULSE;                         // R16
        end else if (fw_set_act) begin
            nxt_st.set_cnt = st_ff.set_cnt - `LATCH_CNT_ONE;          // R18
        end
        if (wr_fw_rst) begin
            nxt_st.rst_cnt = `LATCH_FW_PULSE;                         // R16
        end else if (fw_rst_act) begin
            nxt_st.rst_cnt = st_ff.rst_cnt - `LATCH_CNT_ONE;          // R18
        end

        // latch core, reset dominant
        if (rst_req) begin
            nxt_st.state = 1'b0;                                      // R13
            nxt_st.known = 1'b1;
        end else if (set_req) begin
            nxt_st.state = 1'b1;
            nxt_st.known = 1'b1;
        end

        // read data stand one cycle after the strobe only
        nxt_st.rdata = `LATCH_RD_ZERO;
        if (reg_re && reg_addr == `LATCH_OFS_MAIN) begin
            nxt_st.rdata = st_ff.ctl & `LATCH_MAIN_RD_MASK;           // R6 R7
        end else if (reg_re && reg_addr == `LATCH_OFS_SRC) begin
            nxt_st.rdata = st_ff.src;
        end

        // pin mux: latch output or the port's own data; the driver enable always comes from the port
        nxt_st.pin_out = drive_latch ? pin_level : port_data_out;     // R4 R5 R15
        nxt_st.pin_oe  = port_drive_en;
        nxt_st.q       = st_ff.known && st_ff.state;
        nxt_st.qn      = st_ff.known && !st_ff.state;

        // device reset: everything but the latch state bit itself
        if (rst) begin
            nxt_st.ctl     = `LATCH_MAIN_RESET;                       // R12
            nxt_st.src     = `LATCH_SRC_RESET;                        // R12
            nxt_st.set_cnt = `LATCH_CNT_ZERO;
            nxt_st.rst_cnt = `LATCH_CNT_ZERO;
            nxt_st.c1_sy   = '0;
            nxt_st.c2_sy   = '0;
            nxt_st.int_sy  = '0;
            nxt_st.state   = st_ff.state;                             // R14
            nxt_st.known   = 1'b0;                                    // R14
            nxt_st.rdata   = `LATCH_RD_ZERO;
            nxt_st.pin_out = 1'b0;
            nxt_st.pin_oe  = 1'b0;
            nxt_st.q       = 1'b0;
            nxt_st.qn      = 1'b0;
        end
    end

    // one register for all state
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    // outputs straight from flip-flops
    assign reg_rdata                 = st_ff.rdata;
    assign latch_output_port_pin_out = st_ff.pin_out;
    assign latch_output_port_pin_oe  = st_ff.pin_oe;
    assign latch_q                   = st_ff.q;
    assign latch_qn                  = st_ff.qn;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_fw_set_write;
        wr_fw_set;
    endsequence

    sequence s_two_cycle_set;
        fw_set_act [*2];
    endsequence

    sequence s_fw_rst_write;
        wr_fw_rst;
    endsequence

    sequence s_two_cycle_rst;
        fw_rst_act [*2];
    endsequence

    chk_fw_set_pulse: assert property ( // R16
        s_fw_set_write |=> s_two_cycle_set)
        else $error("firmware set pulse not two cycles");

    chk_fw_rst_pulse: assert property ( // R16
        s_fw_rst_write |=> s_two_cycle_rst)
        else $error("firmware reset pulse not two cycles");

    chk_fw_self_clear: assert property ( // R18
        wr_fw_set && !latch_on ##1 !wr_fw_set [*2] |=> !fw_set_act)
        else $error("firmware set pulse did not end");

    chk_pulse_bits_read: assert property ( // R6
        reg_re && reg_addr == `LATCH_OFS_MAIN
        |=> reg_rdata[`LATCH_BIT_FW_SET:`LATCH_BIT_FW_RST] == 2'h0)
        else $error("pulse bits read back nonzero");

    chk_reset_wins: assert property ( // R13
        rst_req |=> !st_ff.state ##1 !latch_q && latch_qn)
        else $error("reset did not dominate the latch");

    chk_set_effect: assert property ( // R17
        set_req && !rst_req |=> st_ff.state ##1 latch_q)
        else $error("set request did not set the latch");

    chk_disabled_quiet: assert property ( // R1
        !latch_on |-> !set_req && !rst_req)
        else $error("disabled latch saw an input");

    chk_clock_set: assert property ( // R10
        latch_on && st_ff.src[`LATCH_BIT_CLK_SET] && div_if.tick |-> set_req)
        else $error("divided clock did not pulse set");

    chk_clock_reset: assert property ( // R11
        latch_on && st_ff.src[`LATCH_BIT_CLK_RST] && div_if.tick |=> !st_ff.state)
        else $error("divided clock did not reset latch");

    chk_port_passthru: assert property ( // R15
        !drive_latch |=> latch_output_port_pin_out == $past(port_data_out))
        else $error("pin not released to the port");

    chk_inverted_pin: assert property ( // R5
        latch_on && nqen |=> latch_output_port_pin_out == !$past(st_ff.state))
        else $error("inverted output not on pin");

    chk_true_pin: assert property ( // R4
        latch_on && qen && !nqen |=> latch_output_port_pin_out == $past(st_ff.state))
        else $error("true output not on pin");

    chk_src_write: assert property ( // R12
        wr_src |=> st_ff.src == $past(reg_wdata))
        else $error("source select write lost");

    chk_regs_reset: assert property (@(posedge clk) disable iff (1'b0) // R12
        rst |=> st_ff.ctl == `LATCH_MAIN_RESET && st_ff.src == `LATCH_SRC_RESET)
        else $error("control registers not cleared by reset");

    chk_div_steer: assert property ( // R1
        !latch_on |=> !div_if.tick)
        else $error("divider ticked while latch disabled");

endmodule

// [testbench/src_model.sv]
// far-side model: both comparators, the interrupt pin and the port's own driver
// assumes the bench commands new levels through put and port_set
`timescale 1ns/1ps

module src_model (
    input  wire logic clk,
    output logic      cmp_one,
    output logic      cmp_two,
    output logic      int_pin,
    output logic      port_dout,
    output logic      port_den
);
    // all sources quiet at power-up
    initial begin
        cmp_one   = 1'b0;
        cmp_two   = 1'b0;
        int_pin   = 1'b0;
        port_dout = 1'b0;
        port_den  = 1'b0;
    end

    // source levels {pin, comparator two, comparator one}, held until changed
    task automatic put(input logic [2:0] lv);
        @(posedge clk);
        {int_pin, cmp_two, cmp_one} <= lv;
    endtask

    // port's own data and driver enable
    task automatic port_set(input logic d, input logic e);
        @(posedge clk);
        port_dout <= d;
        port_den  <= e;
    endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the set-reset latch block
// assumes latch_cfg.svh offsets and the src_model far side
`timescale 1ns/1ps
`include "latch_cfg.svh"

module tb;
    logic                     clk;
    logic                     rst;
    logic [`LATCH_ADDR_W-1:0] reg_addr;
    logic [`LATCH_DATA_W-1:0] reg_wdata;
    logic                     reg_we;
    logic                     reg_re;
    logic [`LATCH_DATA_W-1:0] reg_rdata;
    logic                     c_one;
    logic                     c_two;
    logic                     i_pin;
    logic                     p_dout;
    logic                     p_den;
    logic                     pin_out;
    logic                     pin_oe;
    logic                     latch_q;
    logic                     latch_qn;
    int                       fail_count;
    int                       checks_done;
    int                       cycles;
    int                       t_a;
    int                       t_b;
    logic [7:0]               m;
    logic [7:0]               sb [3] = '{8'h10, 8'h20, 8'h80};
    logic [7:0]               rb [3] = '{8'h01, 8'h02, 8'h08};
    logic [7:0]               mt [5] = '{8'h88, 8'h84, 8'h8C, 8'h80, 8'h08};

    sr_latch_control i_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .comparator_one_output(c_one), .comparator_two_output(c_two),
        .external_interrupt_pin_one(i_pin), .port_data_out(p_dout),
        .port_drive_en(p_den), .latch_output_port_pin_out(pin_out),
        .latch_output_port_pin_oe(pin_oe), .latch_q(latch_q), .latch_qn(latch_qn)
    );

    src_model i_src (
        .clk(clk), .cmp_one(c_one), .cmp_two(c_two), .int_pin(i_pin),
        .port_dout(p_dout), .port_den(p_den)
    );

    // free-running clock
    always #5 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chkn(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rchk(input logic [1:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk8(nm, e, reg_rdata);
    endtask

    task automatic qchk(input int n, input logic v);
        tick(n);
        chk1("latch_q", v, latch_q);
        chk1("latch_qn", ~v, latch_qn);
    endtask

    // cycles until the next falling edge of latch_q, bounded
    task automatic wait_fall(output int n);
        logic prev;
        n = 0;
        prev = latch_q;
        do begin
            tick(1);
            n++;
            if (prev === 1'b1 && latch_q === 1'b0) break;
            prev = latch_q;
        end while (n < 2000);
    endtask

    // main sequence
    initial begin
        clk = 1'b0; rst = 1'b1; reg_addr = '0; reg_wdata = '0;
        reg_we = 1'b0; reg_re = 1'b0;
        fail_count = 0; checks_done = 0; cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        i_src.port_set(1'b1, 1'b1);
        tick(2);
        chk1("latch_q idle", 1'b0, latch_q);
        chk1("latch_qn idle", 1'b0, latch_qn);
        rchk(`LATCH_OFS_MAIN, 8'h00, "main reset");
        rchk(`LATCH_OFS_SRC, 8'h00, "src reset");
        wr(`LATCH_OFS_SRC, 8'hA5);
        rchk(`LATCH_OFS_SRC, 8'hA5, "src rw");
        wr(2'h2, 8'hFF);
        rchk(2'h2, 8'h00, "unmapped");
        rchk(`LATCH_OFS_SRC, 8'hA5, "src kept");
        wr(`LATCH_OFS_MAIN, 8'h7F);
        rchk(`LATCH_OFS_MAIN, 8'h7C, "main rw");
        wr(`LATCH_OFS_SRC, 8'h00);
        // firmware pulses, reset wins, disabled latch holds
        wr(`LATCH_OFS_MAIN, 8'h82); qchk(3, 1'b1);
        rchk(`LATCH_OFS_MAIN, 8'h80, "self clear");
        wr(`LATCH_OFS_MAIN, 8'h83); qchk(3, 1'b0);
        wr(`LATCH_OFS_MAIN, 8'h82); qchk(3, 1'b1);
        wr(`LATCH_OFS_MAIN, 8'h81); qchk(3, 1'b0);
        wr(`LATCH_OFS_MAIN, 8'h02); qchk(3, 1'b0);
        // each external source sets, resets, and is ignored when not enabled
        wr(`LATCH_OFS_MAIN, 8'h80);
        for (int i = 0; i < 3; i++) begin
            wr(`LATCH_OFS_SRC, sb[i]);
            i_src.put(3'(1 << ((i + 1) % 3))); qchk(7, 1'b0);
            i_src.put(3'(1 << i)); qchk(7, 1'b1);
            i_src.put(3'b000);
            wr(`LATCH_OFS_SRC, rb[i]);
            i_src.put(3'(1 << i)); qchk(7, 1'b0);
            i_src.put(3'b000);
        end
        // pin steering with latch set, for both port data levels
        wr(`LATCH_OFS_SRC, 8'h00);
        wr(`LATCH_OFS_MAIN, 8'h82); qchk(3, 1'b1);
        for (int pd = 0; pd < 2; pd++) begin
            i_src.port_set(pd[0], 1'b1);
            for (int k = 0; k < 5; k++) begin
                m = mt[k];
                wr(`LATCH_OFS_MAIN, m);
                tick(3);
                chk1("pin_out", (m[7] & m[2]) ? 1'b0 : (m[7] & m[3]) ? 1'b1 : pd[0],
                     pin_out);
            end
        end
        chk1("pin_oe", 1'b1, pin_oe);
        i_src.port_set(1'b0, 1'b0);
        tick(2);
        chk1("pin_oe off", 1'b0, pin_oe);
        // divider period: comparator one sets, divided clock resets
        wr(`LATCH_OFS_SRC, 8'h14);
        i_src.put(3'b001);
        for (int c = 0; c < 8; c++) begin
            wr(`LATCH_OFS_MAIN, 8'h00);
            wr(`LATCH_OFS_MAIN, 8'h80 | 8'(c << 4));
            wait_fall(t_a);
            wait_fall(t_b);
            chkn("divider period", 4 << c, t_b);
        end
        // divided clock on the set input only when enabled
        i_src.put(3'b000);
        wr(`LATCH_OFS_SRC, 8'h00);
        wr(`LATCH_OFS_MAIN, 8'h00);
        wr(`LATCH_OFS_MAIN, 8'hB0);
        wr(`LATCH_OFS_MAIN, 8'hB1); qchk(3, 1'b0);
        qchk(40, 1'b0);
        wr(`LATCH_OFS_SRC, 8'h40);
        qchk(40, 1'b1);
        // mid-run reset: registers clear, latch outputs wait for firmware
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk1("latch_q after reset", 1'b0, latch_q);
        chk1("latch_qn after reset", 1'b0, latch_qn);
        rchk(`LATCH_OFS_MAIN, 8'h00, "main after reset");
        rchk(`LATCH_OFS_SRC, 8'h00, "src after reset");
        wr(`LATCH_OFS_MAIN, 8'h81); qchk(3, 1'b0);
        test_done();
    end
endmodule
